// File: epw_params.svh
`ifndef EPW_PARAMS_SVH
`define EPW_PARAMS_SVH
// Register addresses
`define EPW_ADR_FLAGS1     4'h0
`define EPW_ADR_ENABLE1    4'h1
`define EPW_ADR_PRIO1      4'h2
`define EPW_ADR_FLAGS2     4'h3
`define EPW_ADR_ENABLE2    4'h4
`define EPW_ADR_PRIO2      4'h5
`define EPW_ADR_TB_COUNT   4'h6
`define EPW_ADR_TB_CTRL    4'h7
`define EPW_ADR_TB_PERIOD  4'h8
`define EPW_ADR_DUTY_LO    4'h9
`define EPW_ADR_DUTY_HI    4'ha
`define EPW_ADR_UNIT_CTRL  4'hb
`define EPW_ADR_SHDN_CTRL  4'hc
`define EPW_ADR_DB_CTRL    4'hd
`define EPW_ADR_PIN_DIR    4'he
`define EPW_ADR_CLK_STAT   4'hf
// Field positions
`define EPW_BIT_OSC_FAIL      7
`define EPW_BIT_TB_MATCH      1
`define EPW_BIT_CAP_CMP       2
`define EPW_BIT_TB_RUN        2
`define EPW_BIT_SHDN_STATUS   7
`define EPW_BIT_RESTART_EN    7
// Implemented-bit masks for the small package, and for enable/priority 2 in both packages
`define EPW_MASK_UNIT_CTRL_SMALL 8'h3f
`define EPW_MASK_SHDN_SMALL      8'hfc
`define EPW_MASK_DB_SMALL        8'h80
`define EPW_MASK_FLAGS2          8'hdf
// Reset values
`define EPW_RST_BYTE      8'h00
`define EPW_RST_PERIOD    8'hff
`define EPW_RST_PIN_DIR   4'hf
`endif

// File: epw_pkg.sv
package epw_pkg;
   typedef enum logic [2:0] {
      EPW_CLK_PRIMARY  = 3'b001,
      EPW_CLK_PM       = 3'b010,
      EPW_CLK_INTERNAL = 3'b100
   } epw_clk_src_t;
   typedef enum logic [3:0] {
      EPW_PM_RUN      = 4'b0001,
      EPW_PM_PRIMARY_CLOCK_IDLE_STATE = 4'b0010,
      EPW_PM_OTHER    = 4'b0100,
      EPW_PM_SLEEP    = 4'b1000
   } epw_pm_state_t;
endpackage : epw_pkg

// File: epw_timebase.sv
`timescale 1ns/1ps
`include "epw_params.svh"
module epw_timebase
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   // Control
   input  wire logic       i_tick,
   input  wire logic       i_run,
   input  wire logic [1:0] i_prescale,
   input  wire logic [3:0] i_postscale,
   input  wire logic [7:0] i_period,
   input  wire logic       i_load,
   input  wire logic [7:0] i_load_val,
   // Status
   output logic [7:0]      o_count,
   output logic            o_period_end,
   output logic            o_match_pulse
);
   logic [3:0] pre_r;
   logic [3:0] post_r;
   logic [7:0] cnt_r;
   logic [3:0] pre_lim;
   logic       adv;
   logic       wrap;
   assign pre_lim = (i_prescale == 2'b00) ? 4'h0 : (i_prescale == 2'b01) ? 4'h3 : 4'hf;
   assign adv = i_tick && i_run && (pre_r == pre_lim);
   assign wrap = adv && (cnt_r == i_period);
   assign o_count = cnt_r;
   assign o_period_end = wrap;
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         pre_r <= 4'h0;
         post_r <= 4'h0;
         cnt_r <= 8'h00;
         o_match_pulse <= 1'b0;
      end
      else
      begin
         o_match_pulse <= wrap && (post_r == i_postscale);
         if (i_load)
         begin
            cnt_r <= i_load_val;
            pre_r <= 4'h0;
         end
         else if (i_tick && i_run)
         begin
            pre_r <= (pre_r == pre_lim) ? 4'h0 : pre_r + 4'h1;
            if (adv)
               cnt_r <= wrap ? 8'h00 : cnt_r + 8'h01;
         end
         if (wrap)
            post_r <= (post_r == i_postscale) ? 4'h0 : post_r + 4'h1;
      end
   end
endmodule : epw_timebase

// File: epw_core.sv
`timescale 1ns/1ps
`include "epw_params.svh"
// Functional notes
// - In sleep with clocks stopped, timebase and PWM state never advance.
// - In sleep, driven PWM pins keep their last level.
// - On wake, PWM and timebase resume from the frozen state.
// - In primary idle, unit keeps running from the primary clock unchanged.
// - Other power-managed states clock the timebase from their selected clock.
// - Clock failure with monitor on enters internal run and sets oscillator-fail flag.
// - After clock failure, PWM continues on the internal oscillator clock.
// - Any reset makes pins inputs and returns all unit registers to reset values.
// - After reset the unit behaves as the plain, non-enhanced unit.
// - Small package: output config, B/D shutdown and deadband bits read zero.
// - Duty value is two separately addressable byte registers, low and high.
module epw_core
#(
   parameter bit SMALL_PKG = 1'b0
)
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   // Register port
   input  wire logic [3:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic [7:0]      o_rdata,
   // Power management and clock ticks
   input  wire logic       i_sleep,
   input  wire logic       i_primary_clock_idle_state,
   input  wire logic       i_pm_other,
   input  wire logic       i_fscm_en,
   input  wire logic       i_pri_fail,
   input  wire logic       i_pri_tick,
   input  wire logic       i_pm_tick,
   input  wire logic       i_int_tick,
   // Shutdown input
   input  wire logic       i_fault,
   // PWM pins
   output logic [3:0]      o_pwm,
   output logic [3:0]      o_pwm_oe,
   // Interrupt
   output logic            o_irq
);
   logic [7:0] flags1_r;
   logic [7:0] en1_r;
   logic [7:0] prio1_r;
   logic [7:0] flags2_r;
   logic [7:0] en2_r;
   logic [7:0] prio2_r;
   logic [7:0] tb_ctrl_r;
   logic [7:0] period_r;
   logic [7:0] duty_lo_r;
   logic [7:0] duty_hi_r;
   logic [7:0] unit_ctrl_r;
   logic [7:0] shdn_r;
   logic [7:0] db_r;
   logic [3:0] pin_dir_r;
   logic       fail_seen_r;
   logic [7:0] duty_lat_r;
   logic [3:0] pwm_r;
   logic [7:0] rdata_r;
   epw_pkg::epw_clk_src_t clk_src;
   epw_pkg::epw_pm_state_t pm_state;
   logic       tick;
   logic       run_en;
   logic [7:0] tb_count;
   logic       period_end;
   logic       match_pulse;
   logic       wr_hit;
   logic       tb_load;
   logic       pwm_mode;
   logic       pwm_level;
   logic       shdn_now;
   logic [1:0] ac_state;
   logic [1:0] bd_state;
   logic [7:0] unit_ctrl_rd;
   logic [7:0] shdn_rd;
   logic [7:0] db_rd;
   logic [7:0] rd_mux;
   logic       pend;

   function automatic logic wr_to(input logic [3:0] a, input logic [3:0] r, input logic w);
      wr_to = w && (a == r);
   endfunction : wr_to

   // Power state and clock source selection
   assign pm_state = i_sleep ? epw_pkg::EPW_PM_SLEEP :
                     i_primary_clock_idle_state ? epw_pkg::EPW_PM_PRIMARY_CLOCK_IDLE_STATE :
                     i_pm_other ? epw_pkg::EPW_PM_OTHER : epw_pkg::EPW_PM_RUN;
   assign clk_src = fail_seen_r ? epw_pkg::EPW_CLK_INTERNAL :
                    (pm_state == epw_pkg::EPW_PM_OTHER) ? epw_pkg::EPW_CLK_PM :
                    epw_pkg::EPW_CLK_PRIMARY;
   always_comb
   begin
      unique case (clk_src)
         epw_pkg::EPW_CLK_PRIMARY:  tick = i_pri_tick;
         epw_pkg::EPW_CLK_PM:       tick = i_pm_tick;
         epw_pkg::EPW_CLK_INTERNAL: tick = i_int_tick;
         default:                   tick = 1'b0;
      endcase
   end
   assign run_en = !i_sleep;

   assign wr_hit = i_wr && run_en;
   assign tb_load = wr_to(i_addr, `EPW_ADR_TB_COUNT, wr_hit);

   epw_timebase u_tb
   (
      .i_clk         (i_clk),
      .i_rstn        (i_rstn),
      .i_tick        (tick && run_en),
      .i_run         (tb_ctrl_r[`EPW_BIT_TB_RUN]),
      .i_prescale    (tb_ctrl_r[1:0]),
      .i_postscale   (tb_ctrl_r[6:3]),
      .i_period      (period_r),
      .i_load        (tb_load),
      .i_load_val    (i_wdata),
      .o_count       (tb_count),
      .o_period_end  (period_end),
      .o_match_pulse (match_pulse)
   );

   // PWM when mode bits are 11xx; reset value 0 is plain mode, single output
   assign pwm_mode = (unit_ctrl_r[3:2] == 2'b11);
   assign pwm_level = ({tb_count, 2'b00} < {duty_lat_r, unit_ctrl_r[5:4]});
   assign shdn_now = shdn_r[`EPW_BIT_SHDN_STATUS];
   assign ac_state = shdn_r[3:2];
   assign bd_state = SMALL_PKG ? 2'b00 : shdn_r[1:0];

   // Read views with unimplemented bits forced to zero
   assign unit_ctrl_rd = SMALL_PKG ? (unit_ctrl_r & `EPW_MASK_UNIT_CTRL_SMALL)
                                   : unit_ctrl_r;
   assign shdn_rd = SMALL_PKG ? (shdn_r & `EPW_MASK_SHDN_SMALL) : shdn_r;
   assign db_rd = SMALL_PKG ? (db_r & `EPW_MASK_DB_SMALL) : db_r;

   assign rd_mux = (i_addr == `EPW_ADR_FLAGS1)    ? flags1_r :
                   (i_addr == `EPW_ADR_ENABLE1)   ? en1_r :
                   (i_addr == `EPW_ADR_PRIO1)     ? prio1_r :
                   (i_addr == `EPW_ADR_FLAGS2)    ? flags2_r :
                   (i_addr == `EPW_ADR_ENABLE2)   ? en2_r :
                   (i_addr == `EPW_ADR_PRIO2)     ? prio2_r :
                   (i_addr == `EPW_ADR_TB_COUNT)  ? tb_count :
                   (i_addr == `EPW_ADR_TB_CTRL)   ? tb_ctrl_r :
                   (i_addr == `EPW_ADR_TB_PERIOD) ? period_r :
                   (i_addr == `EPW_ADR_DUTY_LO)   ? duty_lo_r :
                   (i_addr == `EPW_ADR_DUTY_HI)   ? duty_hi_r :
                   (i_addr == `EPW_ADR_UNIT_CTRL) ? unit_ctrl_rd :
                   (i_addr == `EPW_ADR_SHDN_CTRL) ? shdn_rd :
                   (i_addr == `EPW_ADR_DB_CTRL)   ? db_rd :
                   (i_addr == `EPW_ADR_PIN_DIR)   ? {4'h0, pin_dir_r} :
                   {5'h00, clk_src};

   assign pend = |(flags1_r & en1_r) || |(flags2_r & en2_r);
   assign o_irq = pend;
   assign o_rdata = rdata_r;
   assign o_pwm = pwm_r;
   assign o_pwm_oe = ~pin_dir_r;

   // Read data, one cycle after the strobe
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         rdata_r <= `EPW_RST_BYTE;
      else
         rdata_r <= i_rd ? rd_mux : `EPW_RST_BYTE;
   end

   // Software-owned configuration, frozen while asleep
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         en1_r <= `EPW_RST_BYTE;
         prio1_r <= `EPW_RST_BYTE;
         en2_r <= `EPW_RST_BYTE;
         prio2_r <= `EPW_RST_BYTE;
         tb_ctrl_r <= `EPW_RST_BYTE;
         period_r <= `EPW_RST_PERIOD;
         duty_lo_r <= `EPW_RST_BYTE;
         duty_hi_r <= `EPW_RST_BYTE;
         unit_ctrl_r <= `EPW_RST_BYTE;
         db_r <= `EPW_RST_BYTE;
         pin_dir_r <= `EPW_RST_PIN_DIR;
      end
      else
      begin
         if (wr_to(i_addr, `EPW_ADR_ENABLE1, wr_hit))
            en1_r <= i_wdata;
         if (wr_to(i_addr, `EPW_ADR_PRIO1, wr_hit))
            prio1_r <= i_wdata;
         if (wr_to(i_addr, `EPW_ADR_ENABLE2, wr_hit))
            en2_r <= i_wdata & `EPW_MASK_FLAGS2;
         if (wr_to(i_addr, `EPW_ADR_PRIO2, wr_hit))
            prio2_r <= i_wdata & `EPW_MASK_FLAGS2;
         if (wr_to(i_addr, `EPW_ADR_TB_CTRL, wr_hit))
            tb_ctrl_r <= {1'b0, i_wdata[6:0]};
         if (wr_to(i_addr, `EPW_ADR_TB_PERIOD, wr_hit))
            period_r <= i_wdata;
         if (wr_to(i_addr, `EPW_ADR_DUTY_LO, wr_hit))
            duty_lo_r <= i_wdata;
         if (wr_to(i_addr, `EPW_ADR_DUTY_HI, wr_hit))
            duty_hi_r <= i_wdata;
         if (wr_to(i_addr, `EPW_ADR_UNIT_CTRL, wr_hit))
            unit_ctrl_r <= i_wdata;
         if (wr_to(i_addr, `EPW_ADR_DB_CTRL, wr_hit))
            db_r <= i_wdata;
         if (wr_to(i_addr, `EPW_ADR_PIN_DIR, wr_hit))
            pin_dir_r <= i_wdata[3:0];
      end
   end

   // Flags: hardware set wins over a write-one clear
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         flags1_r <= `EPW_RST_BYTE;
         flags2_r <= `EPW_RST_BYTE;
         fail_seen_r <= 1'b0;
      end
      else
      begin
         flags1_r <= (flags1_r & ~(wr_to(i_addr, `EPW_ADR_FLAGS1, i_wr) ? i_wdata : 8'h00))
                     | {5'h00, period_end && pwm_mode && run_en, match_pulse && run_en, 1'b0};
         flags2_r <= (flags2_r & ~(wr_to(i_addr, `EPW_ADR_FLAGS2, i_wr) ? i_wdata : 8'h00))
                     | {i_fscm_en && i_pri_fail && !fail_seen_r, 7'h00};
         if (i_fscm_en && i_pri_fail)
            fail_seen_r <= 1'b1;
         else if (!i_pri_fail)
            fail_seen_r <= 1'b0;
      end
   end

   // Shutdown control; status clears by software or on restart at period end
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
         shdn_r <= `EPW_RST_BYTE;
      else if (run_en)
      begin
         if (wr_to(i_addr, `EPW_ADR_SHDN_CTRL, i_wr))
            shdn_r <= (i_fault && (shdn_r[6:4] != 3'b000)) ? (i_wdata | 8'h80) : i_wdata;
         else if ((shdn_r[6:4] != 3'b000) && i_fault)
            shdn_r[`EPW_BIT_SHDN_STATUS] <= 1'b1;
         else if (db_r[`EPW_BIT_RESTART_EN] && period_end)
            shdn_r[`EPW_BIT_SHDN_STATUS] <= 1'b0;
      end
   end

   // Duty latch and pin levels; all held across sleep and resumed unchanged
   always_ff @(posedge i_clk)
   begin
      if (!i_rstn)
      begin
         duty_lat_r <= `EPW_RST_BYTE;
         pwm_r <= 4'h0;
      end
      else if (run_en)
      begin
         if (period_end)
            duty_lat_r <= duty_lo_r;
         if (shdn_now)
            pwm_r <= {bd_state[0], ac_state[0], bd_state[0], ac_state[0]};
         else if (pwm_mode)
            pwm_r <= {3'b000, pwm_level ^ unit_ctrl_r[1]};
         else
            pwm_r <= 4'h0;
      end
      else
         pwm_r <= pwm_r;
   end
endmodule : epw_core

// File: epw_switch_model.sv
`timescale 1ns/1ps
module epw_switch_model
(
   // Pin side
   input  wire logic [3:0] i_pwm,
   input  wire logic [3:0] i_pwm_oe,
   // Switch gates
   output logic [3:0]      o_gate
);
   // Pull-downs hold a switch off while its pin is an input
   assign o_gate = i_pwm & i_pwm_oe;
endmodule : epw_switch_model

// File: epw_core_properties.sv
`timescale 1ns/1ps
module epw_core_properties
(
   // Clock and reset
   input wire logic       i_clk,
   input wire logic       i_rstn,
   // Register port
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rdata,
   // Power management
   input wire logic       i_sleep,
   input wire logic       i_primary_clock_idle_state,
   input wire logic       i_pm_other,
   input wire logic       i_fscm_en,
   input wire logic       i_pri_fail,
   // Pins and interrupt
   input wire logic [3:0] o_pwm,
   input wire logic [3:0] o_pwm_oe,
   input wire logic       o_irq
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);
   wire fail_on = i_fscm_en && i_pri_fail;
   wire rd_src  = i_rd && i_addr == 4'hf && !i_sleep;
   a_sleep_pins_hold: assert property ($past(i_sleep) && $past(i_rstn) |-> $stable(o_pwm))
      else $error("pins moved in sleep");
   a_sleep_dir_hold: assert property ($past(i_sleep) && $past(i_rstn) |-> $stable(o_pwm_oe))
      else $error("direction moved in sleep");
   a_reset_all_inputs: assert property (disable iff (1'b0) !i_rstn |=> !o_pwm_oe && !o_irq)
      else $error("pins or irq live after reset");
   a_rdata_idle_zero: assert property ($past(i_rstn) && !$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data outside read slot");
   a_duty_lo_back: assert property (i_wr && i_addr == 4'h9 && !i_sleep ##1
      i_rd && i_addr == 4'h9 |=> o_rdata == $past(i_wdata, 2)) else $error("duty low lost");
   a_duty_hi_back: assert property (i_wr && i_addr == 4'ha && !i_sleep ##1
      i_rd && i_addr == 4'ha |=> o_rdata == $past(i_wdata, 2)) else $error("duty high lost");
   a_fail_src_int: assert property ($past(fail_on) && fail_on && rd_src |=> o_rdata == 8'h04)
      else $error("no internal clock after failure");
   a_idle_src_pri: assert property (!$past(i_pri_fail) && !i_pri_fail && $past(i_primary_clock_idle_state)
      && i_primary_clock_idle_state && !$past(i_pm_other) && !i_pm_other && rd_src |=> o_rdata == 8'h01)
      else $error("idle left primary clock");
   a_pm_src_sel: assert property (!$past(i_pri_fail) && !i_pri_fail && $past(i_pm_other)
      && i_pm_other && !i_primary_clock_idle_state && rd_src |=> o_rdata == 8'h02) else $error("pm clock not used");
   a_fail_flag_set: assert property (i_fscm_en && $rose(i_pri_fail) ##1 (!i_wr)[*3]
      ##1 (i_rd && i_addr == 4'h3) |=> o_rdata[7]) else $error("fail flag not set");
endmodule : epw_core_properties
bind epw_core epw_core_properties chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep),
   .i_primary_clock_idle_state(i_primary_clock_idle_state), .i_pm_other(i_pm_other), .i_fscm_en(i_fscm_en),
   .i_pri_fail(i_pri_fail), .o_pwm(o_pwm), .o_pwm_oe(o_pwm_oe), .o_irq(o_irq));

// File: epw_core_bench.sv
`timescale 1ns/1ps
module epw_core_bench;
   logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, sleep = 1'b0, idle = 1'b0;
   logic       pmo = 1'b0, fscm = 1'b0, fail = 1'b0, pt = 1'b0, mt = 1'b0, it = 1'b0, irq;
   logic [3:0] addr = 4'h0, a, pwm, oe, gate;
   logic [7:0] wdata = 8'h00, d, rdata, rdata2, c0, c1, c2;
   logic [7:0] mdl [16], mdl2 [16];
   int         errors = 0, comparisons = 0, cyc = 0, seed = 69, k;
   epw_core #(.SMALL_PKG(1'b0)) dut (.i_clk(clk), .i_rstn(rstn), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_sleep(sleep),
      .i_primary_clock_idle_state(idle), .i_pm_other(pmo), .i_fscm_en(fscm), .i_pri_fail(fail),
      .i_pri_tick(pt), .i_pm_tick(mt), .i_int_tick(it), .i_fault(1'b0),
      .o_pwm(pwm), .o_pwm_oe(oe), .o_irq(irq));
   epw_core #(.SMALL_PKG(1'b1)) dut2 (.i_clk(clk), .i_rstn(rstn), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata2), .i_sleep(sleep),
      .i_primary_clock_idle_state(idle), .i_pm_other(pmo), .i_fscm_en(fscm), .i_pri_fail(fail),
      .i_pri_tick(pt), .i_pm_tick(mt), .i_int_tick(it), .i_fault(1'b0),
      .o_pwm(), .o_pwm_oe(), .o_irq());
   epw_switch_model sw (.i_pwm(pwm), .i_pwm_oe(oe), .o_gate(gate));
   initial
   begin
      forever #2.5 clk = ~clk;
   end
   task conclude;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 10000)
      begin
         errors++;
         conclude();
      end
   end
   task check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task bus(input logic w, input logic r, input logic [3:0] ad, input logic [7:0] dt);
      wr <= w;
      rd <= r;
      addr <= ad;
      wdata <= dt;
      @(posedge clk);
   endtask : bus
   task wreg(input logic [3:0] ad, input logic [7:0] dt);
      bus(1'b1, 1'b0, ad, dt);
      bus(1'b0, 1'b0, ad, dt);
   endtask : wreg
   // Read data is taken one step after the edge that registers it
   task rget(input logic [3:0] ad);
      bus(1'b0, 1'b1, ad, 8'h00);
      rd <= 1'b0;
      #1;
      c1 = rdata;
      c2 = rdata2;
      @(posedge clk);
   endtask : rget
   task rchk(input logic [3:0] ad);
      rget(ad);
      check(c1, mdl[ad]);
      check(c2, mdl2[ad]);
   endtask : rchk
   task rst_chk;
      rstn <= 1'b0;
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      for (k = 0; k < 16; k++)
      begin
         mdl[k] = k == 8 ? 8'hff : k == 14 ? 8'h0f : k == 15 ? 8'h01 : 8'h00;
         mdl2[k] = mdl[k];
         rchk(4'(k));
      end
      check({4'h0, oe}, 8'h00);
      check({4'h0, gate}, 8'h00);
      $display("reset test done");
   endtask : rst_chk
   initial
   begin
      rst_chk();
      for (k = 0; k < 24; k++)
      begin
         a = 4'(32'hdcba9854 >> (4 * (k % 8)));
         d = 8'($random(seed));
         if (a == 4'hc)
            d[7] = 1'b0;
         mdl[a] = a < 4'h6 ? d & 8'hdf : d;
         mdl2[a] = a == 4'hb ? d & 8'h3f : a == 4'hc ? d & 8'hfc : a == 4'hd ? d & 8'h80 : mdl[a];
         bus(1'b1, 1'b0, a, d);
         rchk(a);
      end
      $display("register test done");
      // Duty of two counts is set; the timebase match raises the interrupt in primary idle
      wreg(4'h9, 8'h02);
      wreg(4'h1, 8'h02);
      wreg(4'h8, 8'h03);
      idle <= 1'b1;
      pt <= 1'b1;
      wreg(4'h7, 8'h04);
      for (k = 0; k < 500 && irq !== 1'b1; k++)
         @(posedge clk);
      check({7'h0, irq}, 8'h01);
      rget(4'hf);
      check(c1, 8'h01);
      pt <= 1'b0;
      idle <= 1'b0;
      wreg(4'h1, 8'h00);
      check({7'h0, irq}, 8'h00);
      wreg(4'h1, 8'h02);
      wreg(4'h0, 8'h02);
      check({7'h0, irq}, 8'h00);
      $display("interrupt test done");
      wreg(4'he, 8'h00);
      wreg(4'hb, 8'h0c);
      check({4'h0, oe}, 8'h0f);
      rget(4'h6);
      c0 = c1;
      pmo <= 1'b1;
      pt <= 1'b1;
      repeat (20) @(posedge clk);
      rget(4'h6);
      check(c1, c0);
      rget(4'hf);
      check(c1, 8'h02);
      d = {4'h0, gate};
      pmo <= 1'b0;
      sleep <= 1'b1;
      {mt, it} <= 2'b11;
      for (k = 0; k < 20; k++)
      begin
         @(posedge clk);
         check({4'h0, gate}, d);
      end
      rget(4'h6);
      check(c1, c0);
      wreg(4'h8, 8'h55);
      {pt, mt, it} <= 3'b000;
      sleep <= 1'b0;
      rget(4'h8);
      check(c1, 8'h03);
      rget(4'h6);
      check(c1, c0);
      $display("sleep test done");
      wreg(4'h8, 8'hff);
      {fscm, fail, it} <= 3'b111;
      repeat (2) @(posedge clk);
      rget(4'hf);
      check(c1, 8'h04);
      rget(4'h3);
      check(c1, 8'h80);
      repeat (20) @(posedge clk);
      rget(4'h6);
      check(8'(c1 !== c0), 8'h01);
      {fscm, fail, it} <= 3'b000;
      wreg(4'h3, 8'h80);
      rget(4'h3);
      check(c1, 8'h00);
      $display("clock fail test done");
      rst_chk();
      conclude();
   end
endmodule : epw_core_bench
